// >>> bench/hmsf_host_model.sv
/*
  host side model: turns a one-cycle request from the bench into an lpc
  i/o event strobe one clock later.
  assumes the bench raises req_i for exactly one cycle per event.
*/
`timescale 1ns/1ps
module hmsf_host_model (
  // clock
  input wire logic sys_clk_i,
  // request from the bench
  input wire logic req_i,
  input wire hmsf_pkg::hmsf_host_ev_s req_ev_i,
  // lpc events towards the device
  output hmsf_pkg::hmsf_host_ev_s host_ev_o
);
  import hmsf_pkg::*;
  initial host_ev_o = '0;
  // idle cycles flip index and address bit so stale values never look valid
  always @(posedge sys_clk_i) begin
    if (req_i) begin
      host_ev_o <= req_ev_i;
    end else begin
      host_ev_o <= '{wr_in_mbox: 1'b0, addr_bit2: ~host_ev_o.addr_bit2, rd_out_mbox: 1'b0,
                     wr_bidir: 1'b0, rd_bidir: 1'b0, bidir_idx: ~host_ev_o.bidir_idx};
    end
  end
endmodule

// >>> bench/hmsf_top_test.sv
/*
  self-checking bench for hmsf_top: random host and local events, checked
  against a flag model at every event.
  assumes the host model and the design files are compiled first.
*/
`timescale 1ns/1ps
module hmsf_top_test;
  import hmsf_pkg::*;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic req = 1'b0;
  hmsf_host_ev_s req_ev = '0;
  hmsf_host_ev_s host_ev;
  hmsf_slave_ev_s slave_ev = '0;
  logic two_way = 1'b0;
  logic alt_sel = 1'b0;
  logic [7:0] alt_st = 8'h00;
  logic [3:0] low_st = 4'h0;
  logic [7:0] st2, st3;
  logic irq2, irq3;
  logic [7:0] m_c2 = 8'h00;
  logic [7:0] m_c3 = 8'h00;
  int seed = 32'h0331CC5E;
  int n_mismatch = 0;
  int check_count = 0;

  always #2.5 sys_clk_i = ~sys_clk_i;

  hmsf_host_model host (.sys_clk_i(sys_clk_i), .req_i(req), .req_ev_i(req_ev), .host_ev_o(host_ev));

  hmsf_top DUT (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .host_ev_i(host_ev), .slave_ev_i(slave_ev),
    .two_way_reg_enable_i(two_way), .alt_status_select_i(alt_sel), .ch3_alt_status_i(alt_st),
    .ch3_low_status_i(low_st), .channel2_status_o(st2), .channel3_bidir_status_o(st3),
    .ch2_input_full_irq_o(irq2), .bidir_input_full_irq_o(irq3));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // set beats clear within one edge, host reg0 write beats local reg0 write
  task automatic model_step(input hmsf_host_ev_s h, input hmsf_slave_ev_s s);
    logic [7:0] set2, clr2, set3, clr3;
    set2 = 8'h00;
    clr2 = 8'h00;
    set3 = 8'h00;
    clr3 = 8'h00;
    if (h.wr_in_mbox) set2[1] = 1'b1;
    if (h.rd_out_mbox) clr2[0] = 1'b1;
    if (s.rd_in_mbox) clr2[1] = 1'b1;
    if (s.wr_out_mbox) set2[0] = 1'b1;
    if (s.wr_ch2_status && !s.wdata[0]) clr2[0] = 1'b1;
    if (h.wr_bidir && h.bidir_idx == 4'hF) set3[7] = 1'b1;
    if (h.wr_bidir && h.bidir_idx == 4'h0 && !m_c3[4]) set3[5] = 1'b1;
    if (h.rd_bidir && h.bidir_idx == 4'hF) clr3 = clr3 | 8'h50;
    if (s.rd_bidir && s.bidir_idx == 4'hF) clr3 = clr3 | 8'hA0;
    if (s.wr_bidir && s.bidir_idx == 4'hF) set3[6] = 1'b1;
    if (s.wr_bidir && s.bidir_idx == 4'h0 && !m_c3[5] && !(h.wr_bidir && h.bidir_idx == 4'h0)) set3[4] = 1'b1;
    // a written 1 must not cancel a host read clear landing in the same cycle
    if (s.wr_ch3_status && (two_way || !alt_sel)) begin
      clr3[6] = clr3[6] | ~s.wdata[6];
      clr3[4] = clr3[4] | ~s.wdata[4];
    end
    m_c2 = (m_c2 & ~clr2) | set2;
    if (s.wr_ch2_status) m_c2 = (m_c2 & 8'h0B) | (s.wdata & 8'hF4);
    if (h.wr_in_mbox) m_c2[3] = h.addr_bit2;
    m_c3 = (m_c3 & ~clr3) | set3;
  endtask

  task automatic check_status();
    logic [7:0] exp3;
    exp3 = (two_way || !alt_sel) ? {m_c3[7:4], low_st} : alt_st;
    check(st2, m_c2);
    check(st3, exp3);
  endtask

  task automatic check_irq();
    check({7'h00, irq2}, {7'h00, m_c2[1]});
    check({7'h00, irq3}, {7'h00, m_c3[7]});
  endtask

  // one host and one local event reach the design on the same edge
  task automatic op(input hmsf_host_ev_s h, input hmsf_slave_ev_s s);
    logic [31:0] r;
    r = $random(seed);
    @(posedge sys_clk_i);
    req <= 1'b1;
    req_ev <= h;
    two_way <= r[0];
    alt_sel <= r[1];
    alt_st <= r[15:8];
    low_st <= r[19:16];
    @(posedge sys_clk_i);
    req <= 1'b0;
    slave_ev <= s;
    @(posedge sys_clk_i);
    slave_ev <= '0;
    model_step(h, s);
    #1;
    check_irq();
    @(posedge sys_clk_i);
    #1;
    check_status();
  endtask

  task automatic do_reset(input int cycles);
    sys_rst_i <= 1'b1;
    repeat (cycles) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    m_c2 = 8'h00;
    m_c3 = 8'h00;
    @(posedge sys_clk_i);
    #1;
    check_irq();
    check_status();
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_mismatch++;
    finish_test();
  end

  initial begin
    hmsf_host_ev_s h;
    hmsf_slave_ev_s s;
    logic [31:0] r;
    do_reset(20);
    h = '0;
    s = '0;
    h.wr_in_mbox = 1'b1;
    h.addr_bit2 = 1'b1;
    op(h, s);
    h = '0;
    s.rd_in_mbox = 1'b1;
    op(h, s);
    for (int i = 0; i < 600; i++) begin
      if (i == 300) do_reset(2);
      r = $random(seed);
      h = r[8:0];
      s = r[26:9];
      r = $random(seed);
      // bias indices towards the first and last registers, which carry flags
      if (r[0]) h.bidir_idx = r[1] ? 4'hF : 4'h0;
      if (r[2]) s.bidir_idx = r[3] ? 4'hF : 4'h0;
      op(h, s);
    end
    finish_test();
  end
endmodule

// >>> logic/hmsf_cfg.svh
/*
  constants for the host mailbox status flag block: bit positions,
  reset values and bidirectional register indices.
  assumes it is included by bare name from the hmsf_top design module only.
*/
`ifndef HMSF_CFG_SVH
`define HMSF_CFG_SVH

`define HMSF_STATUS_RESET 8'h00
`define HMSF_BIDIR_FIRST 4'h0
`define HMSF_BIDIR_LAST 4'hF
`define HMSF_CH2_USER_MASK 8'hF4
`define HMSF_CH2_TAG_BIT 3
`define HMSF_CH2_IBF_BIT 1
`define HMSF_CH2_OBF_BIT 0
`define HMSF_CH3_IBF_BIT 7
`define HMSF_CH3_OBF_BIT 6
`define HMSF_CH3_MWO_BIT 5
`define HMSF_CH3_SWO_BIT 4

`endif

// >>> logic/hmsf_flag.sv
/*
  one sticky status flag with set and clear strobes.
  assumes strobes are synchronous to sys_clk_i.
*/
`timescale 1ns/1ps
module hmsf_flag (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // strobes
  input wire logic set_i,
  input wire logic clr_i,
  // flag
  output logic q_o
);
  // set wins so an event landing on the clearing cycle is not lost
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      q_o <= 1'b0;
    end else if (set_i) begin
      q_o <= 1'b1;
    end else if (clr_i) begin
      q_o <= 1'b0;
    end
  end
endmodule

// >>> logic/hmsf_pkg.sv
/*
  types shared by the host mailbox status flag block.
  assumes nothing, not even the constants header.
*/
package hmsf_pkg;
  // host-side lpc i/o cycle events, each a one-cycle strobe
  typedef struct packed {
    logic wr_in_mbox;
    logic addr_bit2;
    logic rd_out_mbox;
    logic wr_bidir;
    logic rd_bidir;
    logic [3:0] bidir_idx;
  } hmsf_host_ev_s;

  // local cpu bus events, each a one-cycle strobe
  typedef struct packed {
    logic rd_in_mbox;
    logic wr_out_mbox;
    logic wr_ch2_status;
    logic wr_ch3_status;
    logic [7:0] wdata;
    logic wr_bidir;
    logic rd_bidir;
    logic [3:0] bidir_idx;
  } hmsf_slave_ev_s;

  typedef enum logic {
    HMSF_LAYOUT_BIDIR,
    HMSF_LAYOUT_ALT
  } hmsf_layout_e;
endpackage

// >>> logic/hmsf_top.sv
/*
  status flags of the channel-2 mailbox and the channel-3 bidirectional
  register set, seen by the host over lpc i/o and by the local cpu.
  assumes address decode lives outside: every access arrives as a one-cycle
  strobe, synchronous to sys_clk_i, and the data registers are elsewhere.
*/
`timescale 1ns/1ps
`include "hmsf_cfg.svh"
module hmsf_top (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // host lpc i/o events
  input wire hmsf_pkg::hmsf_host_ev_s host_ev_i,
  // local cpu events
  input wire hmsf_pkg::hmsf_slave_ev_s slave_ev_i,
  // channel-3 mode controls
  input wire logic two_way_reg_enable_i,
  input wire logic alt_status_select_i,
  // alternate channel-3 layout, kept outside this block
  input wire logic [7:0] ch3_alt_status_i,
  // low nibble of the bidirectional layout, kept outside this block
  input wire logic [3:0] ch3_low_status_i,
  // status registers
  output logic [7:0] channel2_status_o,
  output logic [7:0] channel3_bidir_status_o,
  // interrupt requests to the local cpu
  output logic ch2_input_full_irq_o,
  output logic bidir_input_full_irq_o
);
  import hmsf_pkg::*;

  logic [7:0] ch2_user;
  logic ch2_command_tag;
  logic ch2_input_full;
  logic ch2_output_full;
  logic bidir_input_full;
  logic bidir_output_full;
  logic master_write_owner;
  logic slave_write_owner;
  hmsf_layout_e layout;

  logic host_wr_first;
  logic host_wr_last;
  logic host_rd_last;
  logic slave_wr_first;
  logic slave_wr_last;
  logic slave_rd_last;
  logic ch3_wr_bidir_view;
  logic ch2_obf_clr;
  logic bobf_clr;
  logic swo_clr;
  logic mwo_set;
  logic swo_set;
  logic [7:0] next_ch2_status;
  logic [7:0] next_ch3_status;

  // decoded bidirectional register accesses
  assign host_wr_first = host_ev_i.wr_bidir && (host_ev_i.bidir_idx == `HMSF_BIDIR_FIRST);
  assign host_wr_last = host_ev_i.wr_bidir && (host_ev_i.bidir_idx == `HMSF_BIDIR_LAST);
  assign host_rd_last = host_ev_i.rd_bidir && (host_ev_i.bidir_idx == `HMSF_BIDIR_LAST);
  assign slave_wr_first = slave_ev_i.wr_bidir && (slave_ev_i.bidir_idx == `HMSF_BIDIR_FIRST);
  assign slave_wr_last = slave_ev_i.wr_bidir && (slave_ev_i.bidir_idx == `HMSF_BIDIR_LAST);
  assign slave_rd_last = slave_ev_i.rd_bidir && (slave_ev_i.bidir_idx == `HMSF_BIDIR_LAST);

  // layout select
  always_comb begin
    if (two_way_reg_enable_i || !alt_status_select_i) begin
      layout = HMSF_LAYOUT_BIDIR;
    end else begin
      layout = HMSF_LAYOUT_ALT;
    end
  end

  // clearing writes only act on the bidir view while it is the one shown
  assign ch3_wr_bidir_view = slave_ev_i.wr_ch3_status && (layout == HMSF_LAYOUT_BIDIR);

  // a written 1 is simply not a clear, so it leaves the flag alone
  assign ch2_obf_clr = host_ev_i.rd_out_mbox ||
    (slave_ev_i.wr_ch2_status && !slave_ev_i.wdata[`HMSF_CH2_OBF_BIT]);
  assign bobf_clr = host_rd_last ||
    (ch3_wr_bidir_view && !slave_ev_i.wdata[`HMSF_CH3_OBF_BIT]);
  assign swo_clr = host_rd_last ||
    (ch3_wr_bidir_view && !slave_ev_i.wdata[`HMSF_CH3_SWO_BIT]);

  // ownership: host write of register 0 blocks a simultaneous local claim
  assign mwo_set = host_wr_first && !slave_write_owner;
  assign swo_set = slave_wr_first && !master_write_owner && !host_wr_first;

  // user bits: only the local cpu writes them
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ch2_user <= `HMSF_STATUS_RESET;
    end else if (slave_ev_i.wr_ch2_status) begin
      ch2_user <= slave_ev_i.wdata & `HMSF_CH2_USER_MASK;
    end
  end

  // command/data tag follows every host write of the input mailbox
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ch2_command_tag <= 1'b0;
    end else if (host_ev_i.wr_in_mbox) begin
      ch2_command_tag <= host_ev_i.addr_bit2;
    end
  end

  // channel-2 input full
  hmsf_flag u_ch2_ibf (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(host_ev_i.wr_in_mbox),
    .clr_i(slave_ev_i.rd_in_mbox),
    .q_o(ch2_input_full)
  );

  // channel-2 output full
  hmsf_flag u_ch2_obf (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(slave_ev_i.wr_out_mbox),
    .clr_i(ch2_obf_clr),
    .q_o(ch2_output_full)
  );

  // bidirectional input full
  hmsf_flag u_bidir_ibf (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(host_wr_last),
    .clr_i(slave_rd_last),
    .q_o(bidir_input_full)
  );

  // bidirectional output full
  hmsf_flag u_bidir_obf (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(slave_wr_last),
    .clr_i(bobf_clr),
    .q_o(bidir_output_full)
  );

  // master write owner
  hmsf_flag u_master_owner (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(mwo_set),
    .clr_i(slave_rd_last),
    .q_o(master_write_owner)
  );

  // slave write owner
  hmsf_flag u_slave_owner (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(swo_set),
    .clr_i(swo_clr),
    .q_o(slave_write_owner)
  );

  // status images
  always_comb begin
    next_ch2_status = ch2_user;
    next_ch2_status[`HMSF_CH2_TAG_BIT] = ch2_command_tag;
    next_ch2_status[`HMSF_CH2_IBF_BIT] = ch2_input_full;
    next_ch2_status[`HMSF_CH2_OBF_BIT] = ch2_output_full;
  end

  always_comb begin
    unique case (layout)
      HMSF_LAYOUT_BIDIR: begin
        next_ch3_status = {bidir_input_full, bidir_output_full,
                           master_write_owner, slave_write_owner, ch3_low_status_i};
      end
      HMSF_LAYOUT_ALT: begin
        next_ch3_status = ch3_alt_status_i;
      end
    endcase
  end

  // registered images trade one cycle of latency for glitch-free reads
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      channel2_status_o <= `HMSF_STATUS_RESET;
    end else begin
      channel2_status_o <= next_ch2_status;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      channel3_bidir_status_o <= `HMSF_STATUS_RESET;
    end else begin
      channel3_bidir_status_o <= next_ch3_status;
    end
  end

  // interrupts are level requests straight from the flag flops
  assign ch2_input_full_irq_o = ch2_input_full;
  assign bidir_input_full_irq_o = bidir_input_full;

  AST_USER_BITS: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    slave_ev_i.wr_ch2_status |=> ##1
      ((channel2_status_o & `HMSF_CH2_USER_MASK) == ($past(slave_ev_i.wdata, 2) & `HMSF_CH2_USER_MASK)))
    else $error("user bits do not follow local write");

  AST_USER_HOLD: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !slave_ev_i.wr_ch2_status |=> $stable(ch2_user))
    else $error("user bits changed without local write");

  AST_TAG_LATCH: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    host_ev_i.wr_in_mbox |=> ##1 (channel2_status_o[`HMSF_CH2_TAG_BIT] == $past(host_ev_i.addr_bit2, 2)))
    else $error("command tag not latched from address bit 2");

  AST_CH2_IBF_SET: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    host_ev_i.wr_in_mbox |=> ch2_input_full ##1 channel2_status_o[`HMSF_CH2_IBF_BIT])
    else $error("input full not set by host write");

  AST_CH2_IBF_CLR: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (slave_ev_i.rd_in_mbox && !host_ev_i.wr_in_mbox) |=> !ch2_input_full)
    else $error("input full not cleared by local read");

  AST_CH2_IRQ: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(ch2_input_full) |-> ch2_input_full_irq_o ##1 channel2_status_o[`HMSF_CH2_IBF_BIT])
    else $error("input full interrupt missing");

  AST_CH2_OBF_SET: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    slave_ev_i.wr_out_mbox |=> ch2_output_full)
    else $error("output full not set by local write");

  AST_CH2_OBF_CLR: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (host_ev_i.rd_out_mbox && !slave_ev_i.wr_out_mbox) |=> !ch2_output_full)
    else $error("output full not cleared by host read");

  AST_CH2_OBF_ONE: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (slave_ev_i.wr_ch2_status && slave_ev_i.wdata[`HMSF_CH2_OBF_BIT] && !ch2_output_full &&
     !slave_ev_i.wr_out_mbox) |=> !ch2_output_full)
    else $error("written 1 set output full");

  AST_LAYOUT: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (!two_way_reg_enable_i && alt_status_select_i) |=> (channel3_bidir_status_o == $past(ch3_alt_status_i)))
    else $error("alternate layout not shown");

  AST_BIBF_SET: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    host_wr_last |=> bidir_input_full)
    else $error("bidir input full not set");

  AST_BIBF_CLR: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (slave_rd_last && !host_wr_last) |=> !bidir_input_full && !bidir_input_full_irq_o)
    else $error("bidir input full not cleared");

  AST_BOBF_SET: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    slave_wr_last |=> bidir_output_full)
    else $error("bidir output full not set");

  AST_BOBF_CLR: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (host_rd_last && !slave_wr_last) |=> !bidir_output_full)
    else $error("bidir output full not cleared by host read");

  AST_MWO_SET: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (host_wr_first && !slave_write_owner) |=> master_write_owner)
    else $error("master owner not set");

  AST_MWO_CLR: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (slave_rd_last && !mwo_set) |=> !master_write_owner)
    else $error("master owner not cleared");

  AST_SWO_PRIO: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (host_wr_first && slave_wr_first && !slave_write_owner) |=>
      (master_write_owner && !slave_write_owner))
    else $error("host did not win ownership tie");

  AST_SWO_CLR: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (host_rd_last && !swo_set) |=> !slave_write_owner)
    else $error("slave owner not cleared by host read");

  AST_OWN_EXCL: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !(master_write_owner && $rose(slave_write_owner)))
    else $error("slave owner set while master owns");

  AST_TAG_STABLE: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !host_ev_i.wr_in_mbox |=> $stable(ch2_command_tag))
    else $error("command tag changed without host write");

  AST_CH2_IBF_RISE: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(ch2_input_full) |-> $past(host_ev_i.wr_in_mbox))
    else $error("input full rose without host write");

  AST_CH2_IRQ_LAG: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    channel2_status_o[`HMSF_CH2_IBF_BIT] |-> $past(ch2_input_full_irq_o))
    else $error("input full shown without prior interrupt");

  AST_CH2_OBF_RISE: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(ch2_output_full) |-> $past(slave_ev_i.wr_out_mbox))
    else $error("output full rose without output mailbox write");

  AST_CH3_BIDIR_VIEW: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (two_way_reg_enable_i || !alt_status_select_i) |=> (channel3_bidir_status_o ==
      $past({bidir_input_full, bidir_output_full, master_write_owner, slave_write_owner, ch3_low_status_i})))
    else $error("bidirectional layout not shown");

  AST_BIBF_RISE: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(bidir_input_full_irq_o) |-> $past(host_wr_last))
    else $error("bidir interrupt rose without host write");

  AST_BOBF_RISE: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(bidir_output_full) |-> $past(slave_wr_last))
    else $error("bidir output full rose without local write");

  AST_MWO_RISE: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(master_write_owner) |-> $past(host_wr_first))
    else $error("master owner rose without host write");

  AST_SWO_RISE: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(slave_write_owner) |-> $past(slave_wr_first))
    else $error("slave owner rose without local write");

  AST_RESET: assert property (
    @(posedge sys_clk_i)
    $past(sys_rst_i) |-> (channel2_status_o == `HMSF_STATUS_RESET) && !ch2_input_full && !slave_write_owner)
    else $error("state not zero after reset");
endmodule
